//--- pcdo_chk_monitor.sv
/*
  Port checker for the clock divider block.
  Assumes it is bound to the block.
*/
`timescale 1ns/1ps
module pcdo_chk_monitor (
  // Clock and reset
  input logic                          MCLK,
  input logic                          RST_N,
  // Settings
  input pcdo_pkg::pcdo_fb_mode_t       FB_MODE,
  input pcdo_pkg::pcdo_div_cfg_t [4:0] DIV_CFG,
  input pcdo_pkg::pcdo_ext_cfg_t       EXT_CFG,
  input logic                          RECONFIG,
  input logic [1:0]                    GPIO_OUT,
  input logic [1:0]                    GPIO_OE,
  // Outputs
  input logic                          EXT_POS_O,
  input logic                          EXT_POS_OE,
  input logic                          EXT_NEG_O,
  input logic                          EXT_NEG_OE,
  input logic [4:0]                    GNET_OUT,
  input logic                          PFD_UP,
  input logic                          PFD_DN,
  input logic                          LOCKED,
  input pcdo_pkg::pcdo_fb_mode_t       FB_MODE_Q,
  input logic [4:0]                    DIV_ERR,
  input logic                          NM_ERR
);
  // ******************
  // Helpers
  // ******************
  logic [1:0]              ok_ff;
  pcdo_pkg::pcdo_ext_cfg_t ext_ff;
  logic [4:0]              bad_v;

  function automatic logic bad(pcdo_pkg::pcdo_div_cfg_t c);
    logic [9:0] s;
    s = {1'b0, c.hi} + {1'b0, c.lo};
    if (s == 10'h001) return 1'b0;
    return (c.hi == 9'h000) || (c.lo == 9'h000) ||
           (s > ((c.hi == c.lo) ? 10'h200 : 10'h100));
  endfunction : bad

  always_comb begin
    for (int i = 0; i < 5; i++) bad_v[i] = bad(DIV_CFG[i]);
  end

  // Pin use strap taken at first edge after release
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ok_ff  <= 2'h0;
      ext_ff <= '0;
    end else begin
      ok_ff <= {ok_ff[0], 1'b1};
      if (!ok_ff[0]) ext_ff <= EXT_CFG;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  property p_pos_src;
    ok_ff[1] && ext_ff.ext_en |-> EXT_POS_OE && (EXT_POS_O == GNET_OUT[0]);
  endproperty
  a_pos_src: assert property (p_pos_src)
    else $error("pos pin source");
  property p_neg_inv;
    ok_ff[1] && ext_ff.ext_en && ext_ff.ext_diff |->
      EXT_NEG_OE && (EXT_NEG_O != EXT_POS_O);
  endproperty
  a_neg_inv: assert property (p_neg_inv)
    else $error("neg not inverse");
  property p_gpio_pos;
    ok_ff[1] && !ext_ff.ext_en |->
      {EXT_POS_O, EXT_POS_OE} == $past({GPIO_OUT[0], GPIO_OE[0]});
  endproperty
  a_gpio_pos: assert property (p_gpio_pos)
    else $error("pos not gpio");
  property p_gpio_neg;
    ok_ff[1] && !ext_ff.ext_diff |->
      {EXT_NEG_O, EXT_NEG_OE} == $past({GPIO_OUT[1], GPIO_OE[1]});
  endproperty
  a_gpio_neg: assert property (p_gpio_neg)
    else $error("neg not gpio");
  property p_err_range;
    RECONFIG |-> ##3 (DIV_ERR == $past(bad_v, 3));
  endproperty
  a_err_range: assert property (p_err_range)
    else $error("div flag wrong");
  property p_err_quiet;
    |DIV_ERR |=> ((GNET_OUT & $past(DIV_ERR)) == 5'h00);
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("bad div toggles");
  property p_pfd_excl;
    !(PFD_UP && PFD_DN);
  endproperty
  a_pfd_excl: assert property (p_pfd_excl)
    else $error("up and down");
  property p_nm_unlock;
    NM_ERR [*3] |-> !LOCKED;
  endproperty
  a_nm_unlock: assert property (p_nm_unlock)
    else $error("lock with bad loop");
  property p_mode_keep;
    RECONFIG |-> ##2 (FB_MODE_Q == $past(FB_MODE, 2));
  endproperty
  a_mode_keep: assert property (p_mode_keep)
    else $error("mode lost");

  c_diff: cover property (ok_ff[1] && ext_ff.ext_diff && $rose(EXT_POS_O));
  c_lock: cover property ($rose(LOCKED));
  c_err:  cover property ($rose(|DIV_ERR));
endmodule : pcdo_chk_monitor

bind pll_clock_divider_outputs pcdo_chk_monitor u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .FB_MODE(FB_MODE), .DIV_CFG(DIV_CFG),
  .EXT_CFG(EXT_CFG), .RECONFIG(RECONFIG), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE(GPIO_OE), .EXT_POS_O(EXT_POS_O), .EXT_POS_OE(EXT_POS_OE),
  .EXT_NEG_O(EXT_NEG_O), .EXT_NEG_OE(EXT_NEG_OE), .GNET_OUT(GNET_OUT),
  .PFD_UP(PFD_UP), .PFD_DN(PFD_DN), .LOCKED(LOCKED),
  .FB_MODE_Q(FB_MODE_Q), .DIV_ERR(DIV_ERR), .NM_ERR(NM_ERR));

//--- pcdo_freq_div.sv
/*
  Frequency divider: one pulse per div ticks.
  Assumes tick and restart come from logic on the same clock.
*/
`timescale 1ns/1ps
module pcdo_freq_div (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Control
  input  wire logic                      restart,
  input  wire logic                      tick,
  input  wire logic [pcdo_pkg::DV_W-1:0] div,
  // Result
  output logic                           pulse_ff,
  output logic                           div_err
);

  logic [pcdo_pkg::DV_W-1:0] cnt_ff;
  logic                      ok;

  assign ok      = (div != 10'h000) && (div <= pcdo_pkg::NM_MAX);
  assign div_err = ~ok;

  // Division only, no high/low shaping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= 10'h000;
      pulse_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff   <= 10'h000;
      pulse_ff <= 1'b0;
    end else if (tick && ok) begin
      if (cnt_ff >= div - 10'h001) begin
        cnt_ff   <= 10'h000;
        pulse_ff <= 1'b1;
      end else begin
        cnt_ff   <= cnt_ff + 10'h001;
        pulse_ff <= 1'b0;
      end
    end else begin
      pulse_ff <= 1'b0;
    end
  end

endmodule : pcdo_freq_div

//--- pcdo_pkg.sv
/*
  Constants, state codes and carrier types for the divider block.
  Assumes one oscillator clock drives every counter.
*/
package pcdo_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_DIV = 5;
  localparam int HL_W    = 9;
  localparam int DV_W    = 10;
  localparam int SYNC_N  = 3;
  localparam int LOCK_W  = 5;
  localparam int ERR_W   = 4;

  // ****************************************
  // Ranges and positions
  // ****************************************
  localparam logic [DV_W-1:0] DIV_MAX_EVEN = 10'h200;
  localparam logic [DV_W-1:0] DIV_MAX_ODD  = 10'h100;
  localparam logic [DV_W-1:0] NM_MAX       = 10'h200;
  localparam int SYNC_REF = 0;
  localparam int SYNC_POS = 1;
  localparam int SYNC_NEG = 2;

  // ****************************************
  // Timing counts and reset values
  // ****************************************
  localparam logic [LOCK_W-1:0] LOCK_REFS = 5'h10;
  localparam logic [ERR_W-1:0]  ERR_MID   = 4'h8;
  localparam logic [ERR_W-1:0]  ERR_TOP   = 4'hF;
  localparam logic [ERR_W-1:0]  ERR_BOT   = 4'h0;
  localparam logic [DV_W-1:0]   RST_DIV   = 10'h001;
  localparam logic [HL_W-1:0]   RST_HL    = 9'h001;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    PCDO_ST_CFG   = 2'h0,
    PCDO_ST_ACQ   = 2'h1,
    PCDO_ST_LOCK  = 2'h3,
    PCDO_ST_RECFG = 2'h2
  } pcdo_state_t;

  typedef enum logic [1:0] {
    PCDO_FB_SRCSYNC = 2'h0,
    PCDO_FB_NOCOMP  = 2'h1,
    PCDO_FB_NORMAL  = 2'h2,
    PCDO_FB_ZDB     = 2'h3
  } pcdo_fb_mode_t;

  typedef struct packed {
    logic [HL_W-1:0] hi;
    logic [HL_W-1:0] lo;
  } pcdo_div_cfg_t;

  typedef struct packed {
    logic ext_en;
    logic ext_diff;
  } pcdo_ext_cfg_t;

endpackage : pcdo_pkg

//--- pcdo_post_div.sv
/*
  Post-scale divider: output high for hi ticks, then low for lo ticks.
  Assumes tick and restart come from logic on the same clock.
*/
`timescale 1ns/1ps
module pcdo_post_div (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Control
  input  wire logic                    restart,
  input  wire logic                    tick,
  input  wire pcdo_pkg::pcdo_div_cfg_t cfg,
  // Result
  output logic                         out_ff,
  output logic                         wrap_ff,
  output logic                         cfg_err
);

  logic [pcdo_pkg::DV_W-1:0] sum;
  logic [pcdo_pkg::DV_W-1:0] cnt_ff;
  logic [pcdo_pkg::DV_W-1:0] nxt_cnt;
  logic                      bypass;
  logic                      ok;

  assign sum     = {1'b0, cfg.hi} + {1'b0, cfg.lo};
  assign bypass  = (sum == 10'h001);
  // Equal halves reach 512, uneven ones stop at 256
  assign ok      = bypass || ((cfg.hi != 9'h000) && (cfg.lo != 9'h000) &&
                   ((cfg.hi == cfg.lo) ? (sum <= pcdo_pkg::DIV_MAX_EVEN)
                                       : (sum <= pcdo_pkg::DIV_MAX_ODD)));
  assign cfg_err = ~ok;
  assign nxt_cnt = (cnt_ff >= sum - 10'h001) ? 10'h000 : cnt_ff + 10'h001;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 10'h000;
      out_ff  <= 1'b0;
      wrap_ff <= 1'b0;
    end else if (restart) begin
      cnt_ff  <= sum - 10'h001;
      out_ff  <= 1'b0;
      wrap_ff <= 1'b0;
    end else begin
      wrap_ff <= tick && ok && (bypass || nxt_cnt == 10'h000);
      if (tick && ok) begin
        cnt_ff <= nxt_cnt;
        // High first, then low, over and over
        out_ff <= bypass || ({1'b0, cfg.hi} > nxt_cnt);
      end else if (bypass || !ok) begin
        out_ff <= 1'b0;
      end
    end
  end

endmodule : pcdo_post_div

//--- pcdo_sink_model.sv
/*
  Far side: unpulled pin pair and run-length meters.
  Assumes every input is on clk.
*/
`timescale 1ns/1ps
module pcdo_sink_model (
  // Clock and reset
  input  logic             clk,
  input  logic             rst_n,
  // Clock network
  input  logic [4:0]       gnet,
  output logic [4:0][11:0] hi_len,
  output logic [4:0][11:0] lo_len,
  // Pin pair, bit 0 positive
  input  logic [1:0]       pin_o,
  input  logic [1:0]       pin_oe,
  output logic [1:0]       pin_lvl
);
  // ******************
  // Meters and pins
  // ******************
  logic [4:0][11:0] run;
  logic [4:0]       prev;

  // Released pin wanders every cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run     <= '0;
      prev    <= '0;
      hi_len  <= '0;
      lo_len  <= '0;
      pin_lvl <= 2'h0;
    end else begin
      pin_lvl <= (pin_oe & pin_o) | (~pin_oe & ~pin_lvl);
      for (int i = 0; i < 5; i++) begin
        prev[i] <= gnet[i];
        if (gnet[i] != prev[i]) begin
          run[i] <= 12'h001;
          if (prev[i]) hi_len[i] <= run[i];
          else lo_len[i] <= run[i];
        end else begin
          run[i] <= run[i] + 12'h001;
        end
      end
    end
  end
endmodule : pcdo_sink_model

//--- pll_clock_divider_outputs.sv
/*
  Counter side of the clock synthesizer: loop counters, lock,
  post-scale and five output dividers, the clock pin pair.
  Assumes MCLK is the oscillator clock;
  REF_CLK and the pin inputs are
  asynchronous to it; all other inputs are on MCLK.
*/
// Contract
// - Only output divider zero reaches the dedicated clock pins directly.
// - Other dividers reach pins only through the global clock outputs.
// - Differential use drives the negative pin as exact inverse.
// - Dedicated clock pins act as general I/O when unused.
// - Every feedback mode keeps division, phase and duty features.
// - Reference divided by pre-scale; oscillator locks at ref times M/N.
// - One pre-scale and one multiply counter, each 1 to 512.
// - Pre-scale divider divides only, no duty control.
// - Five independent output dividers, global or external destination.
// - Equal high/low setting accepts divide 1 to 512.
// - Unequal high/low setting accepts divide 1 to 256.
// - Divide ratio equals high count plus low count.
// - Duty cycle set by separate high and low counts.
// - Duty step is fifty percent over the divide value; the code steps by one count, a hundred percent over it.
// - A divider may be clocked by the previous divider.
// - Cascaded dividers divide by the product of settings.
// - Cascading fixed at configuration, untouched by reconfiguration.
// - Oscillator post-scale of two halves the range seen by dividers.
`timescale 1ns/1ps
module pll_clock_divider_outputs (
  // Clock and reset
  input  wire logic                         MCLK,
  input  wire logic                         RST_N,
  // Reference pin
  input  wire logic                         REF_CLK,
  // Loop settings
  input  wire logic [pcdo_pkg::DV_W-1:0]    N_DIV,
  input  wire logic [pcdo_pkg::DV_W-1:0]    M_DIV,
  input  wire logic                         K_HALF,
  input  wire pcdo_pkg::pcdo_fb_mode_t      FB_MODE,
  // Output divider settings
  input  wire pcdo_pkg::pcdo_div_cfg_t [pcdo_pkg::NUM_DIV-1:0] DIV_CFG,
  input  wire logic [pcdo_pkg::NUM_DIV-1:1] CASCADE_CFG,
  input  wire pcdo_pkg::pcdo_ext_cfg_t      EXT_CFG,
  input  wire logic                         RECONFIG,
  // General I/O use of the clock pins
  input  wire logic [1:0]                   GPIO_OUT,
  input  wire logic [1:0]                   GPIO_OE,
  output logic      [1:0]                   GPIO_IN,
  // Dedicated clock pins
  input  wire logic                         EXT_POS_I,
  output logic                              EXT_POS_O,
  output logic                              EXT_POS_OE,
  input  wire logic                         EXT_NEG_I,
  output logic                              EXT_NEG_O,
  output logic                              EXT_NEG_OE,
  // Global clock network
  output logic [pcdo_pkg::NUM_DIV-1:0]      GNET_OUT,
  // Loop status
  output logic                              PFD_UP,
  output logic                              PFD_DN,
  output logic                              LOCKED,
  output pcdo_pkg::pcdo_fb_mode_t           FB_MODE_Q,
  output logic [pcdo_pkg::NUM_DIV-1:0]      DIV_ERR,
  output logic                              NM_ERR
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam int ND = pcdo_pkg::NUM_DIV;
  localparam int SN = pcdo_pkg::SYNC_N;

  pcdo_pkg::pcdo_state_t            state_ff;
  pcdo_pkg::pcdo_state_t            nxt_state;
  pcdo_pkg::pcdo_div_cfg_t [ND-1:0] div_cfg_ff;
  pcdo_pkg::pcdo_ext_cfg_t          ext_cfg_ff;
  logic [pcdo_pkg::DV_W-1:0]        n_ff;
  logic [pcdo_pkg::DV_W-1:0]        m_ff;
  logic                             k_half_ff;
  logic [ND-1:1]                    cascade_ff;
  logic [SN-1:0]                    sync1_ff;
  logic [SN-1:0]                    sync2_ff;
  logic [SN-1:0]                    sync3_ff;
  logic [SN-1:0]                    lvl_ff;
  logic                             ref_rise;
  logic                             restart;
  logic                             ref_pulse;
  logic                             fb_pulse;
  logic                             n_err;
  logic                             m_err;
  logic [pcdo_pkg::ERR_W-1:0]       err_ff;
  logic [pcdo_pkg::LOCK_W-1:0]      good_ff;
  logic                             vco_tick_ff;
  logic [ND-1:0]                    src_tick;
  logic [ND-1:0]                    div_out;
  logic [ND-1:0]                    div_wrap;
  logic [ND-1:0]                    div_err;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Level moves when stages two and three agree
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
    end else begin
      sync1_ff <= {EXT_NEG_I, EXT_POS_I, REF_CLK};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      lvl_ff <= 3'h0;
    end else begin
      for (int i = 0; i < SN; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          lvl_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  assign ref_rise = sync2_ff[pcdo_pkg::SYNC_REF] &&
                    sync3_ff[pcdo_pkg::SYNC_REF] &&
                    !lvl_ff[pcdo_pkg::SYNC_REF];

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      GPIO_IN <= 2'h0;
    end else begin
      GPIO_IN <= {lvl_ff[pcdo_pkg::SYNC_NEG], lvl_ff[pcdo_pkg::SYNC_POS]};
    end
  end

  // ****************************************
  // Configuration sequencer
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pcdo_pkg::PCDO_ST_CFG:   nxt_state = pcdo_pkg::PCDO_ST_ACQ;
      pcdo_pkg::PCDO_ST_ACQ: begin
        if (RECONFIG) begin
          nxt_state = pcdo_pkg::PCDO_ST_RECFG;
        end else if (good_ff == pcdo_pkg::LOCK_REFS) begin
          nxt_state = pcdo_pkg::PCDO_ST_LOCK;
        end
      end
      pcdo_pkg::PCDO_ST_LOCK: begin
        if (RECONFIG) begin
          nxt_state = pcdo_pkg::PCDO_ST_RECFG;
        end else if (good_ff != pcdo_pkg::LOCK_REFS) begin
          nxt_state = pcdo_pkg::PCDO_ST_ACQ;
        end
      end
      pcdo_pkg::PCDO_ST_RECFG: nxt_state = pcdo_pkg::PCDO_ST_ACQ;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= pcdo_pkg::PCDO_ST_CFG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign restart = (state_ff == pcdo_pkg::PCDO_ST_CFG) ||
                   (state_ff == pcdo_pkg::PCDO_ST_RECFG);

  // ****************************************
  // Settings capture
  // ****************************************
  // Reload at configuration and reconfiguration
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      n_ff       <= pcdo_pkg::RST_DIV;
      m_ff       <= pcdo_pkg::RST_DIV;
      k_half_ff  <= 1'b0;
      FB_MODE_Q  <= pcdo_pkg::PCDO_FB_NORMAL;
      for (int i = 0; i < ND; i++) begin
        div_cfg_ff[i] <= '{hi: pcdo_pkg::RST_HL, lo: pcdo_pkg::RST_HL};
      end
    end else if (state_ff == pcdo_pkg::PCDO_ST_CFG ||
                 (RECONFIG && state_ff != pcdo_pkg::PCDO_ST_RECFG)) begin
      n_ff       <= N_DIV;
      m_ff       <= M_DIV;
      k_half_ff  <= K_HALF;
      // Mode is reported only; counters work alike in all modes
      FB_MODE_Q  <= FB_MODE;
      div_cfg_ff <= DIV_CFG;
    end
  end

  // Straps taken once after reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cascade_ff <= '0;
      ext_cfg_ff <= '{ext_en: 1'b0, ext_diff: 1'b0};
    end else if (state_ff == pcdo_pkg::PCDO_ST_CFG) begin
      cascade_ff <= CASCADE_CFG;
      ext_cfg_ff <= EXT_CFG;
    end
  end

  // ****************************************
  // Pre-scale and multiply counters
  // ****************************************
  // Reference edges divided by N
  pcdo_freq_div u_pre_div (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .restart  (restart),
    .tick     (ref_rise),
    .div      (n_ff),
    .pulse_ff (ref_pulse),
    .div_err  (n_err)
  );

  // Feedback: oscillator over M
  pcdo_freq_div u_mul_div (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .restart  (restart),
    .tick     (1'b1),
    .div      (m_ff),
    .pulse_ff (fb_pulse),
    .div_err  (m_err)
  );

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      NM_ERR <= 1'b0;
    end else begin
      NM_ERR <= n_err | m_err;
    end
  end

  // ****************************************
  // Phase compare and lock
  // ****************************************
  // Saturating pulse balance
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      err_ff <= pcdo_pkg::ERR_MID;
    end else if (restart) begin
      err_ff <= pcdo_pkg::ERR_MID;
    end else if (ref_pulse && !fb_pulse && err_ff != pcdo_pkg::ERR_TOP) begin
      err_ff <= err_ff + 4'h1;
    end else if (fb_pulse && !ref_pulse && err_ff != pcdo_pkg::ERR_BOT) begin
      err_ff <= err_ff - 4'h1;
    end
  end

  // Speed up or slow down
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      PFD_UP <= 1'b0;
      PFD_DN <= 1'b0;
    end else begin
      PFD_UP <= err_ff > pcdo_pkg::ERR_MID;
      PFD_DN <= err_ff < pcdo_pkg::ERR_MID;
    end
  end

  // Consecutive balanced reference pulses
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      good_ff <= 5'h00;
    end else if (restart || NM_ERR) begin
      good_ff <= 5'h00;
    end else if (ref_pulse) begin
      if (err_ff > pcdo_pkg::ERR_MID + 4'h1 ||
          err_ff < pcdo_pkg::ERR_MID - 4'h1) begin
        good_ff <= 5'h00;
      end else if (good_ff != pcdo_pkg::LOCK_REFS) begin
        good_ff <= good_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      LOCKED <= 1'b0;
    end else begin
      LOCKED <= (nxt_state == pcdo_pkg::PCDO_ST_LOCK);
    end
  end

  // ****************************************
  // Oscillator post-scale
  // ****************************************
  // Half rate when set
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      vco_tick_ff <= 1'b0;
    end else if (restart) begin
      vco_tick_ff <= 1'b0;
    end else begin
      vco_tick_ff <= k_half_ff ? ~vco_tick_ff : 1'b1;
    end
  end

  // ****************************************
  // Output dividers
  // ****************************************
  assign src_tick[0] = vco_tick_ff;

  // Chained divider counts wraps of its neighbour
  for (genvar g = 1; g < ND; g++) begin : g_src
    assign src_tick[g] = cascade_ff[g] ? div_wrap[g-1] : vco_tick_ff;
  end

  // Five independent dividers
  for (genvar g = 0; g < ND; g++) begin : g_div
    pcdo_post_div u_post (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .restart (restart),
      .tick    (src_tick[g]),
      .cfg     (div_cfg_ff[g]),
      .out_ff  (div_out[g]),
      .wrap_ff (div_wrap[g]),
      .cfg_err (div_err[g])
    );
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      DIV_ERR <= '0;
    end else begin
      DIV_ERR <= div_err;
    end
  end

  // ****************************************
  // Global network
  // ****************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      GNET_OUT <= '0;
    end else begin
      GNET_OUT <= div_out;
    end
  end

  // ****************************************
  // Dedicated clock pins
  // ****************************************
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      EXT_POS_O  <= 1'b0;
      EXT_POS_OE <= 1'b0;
    end else if (ext_cfg_ff.ext_en) begin
      EXT_POS_O  <= div_out[0];
      EXT_POS_OE <= 1'b1;
    end else begin
      EXT_POS_O  <= GPIO_OUT[0];
      EXT_POS_OE <= GPIO_OE[0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      EXT_NEG_O  <= 1'b0;
      EXT_NEG_OE <= 1'b0;
    end else if (ext_cfg_ff.ext_en && ext_cfg_ff.ext_diff) begin
      EXT_NEG_O  <= ~div_out[0];
      EXT_NEG_OE <= 1'b1;
    end else begin
      EXT_NEG_O  <= GPIO_OUT[1];
      EXT_NEG_OE <= GPIO_OE[1];
    end
  end

endmodule : pll_clock_divider_outputs

//--- pll_clock_divider_outputs_bench.sv
/*
  Self-checking bench for the clock divider block.
  Assumes the checker is bound in.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  errors++; $display("mismatch %s exp %0h got %0h", nm, exp, got); end end
module pll_clock_divider_outputs_bench;
  // ******************
  // Signals
  // ******************
  logic                          mclk, rst_n, ref_clk, k_half, reconfig;
  logic [9:0]                    n_div, m_div;
  pcdo_pkg::pcdo_fb_mode_t       fb_mode, fb_q;
  pcdo_pkg::pcdo_div_cfg_t [4:0] div_cfg;
  logic [4:1]                    casc;
  pcdo_pkg::pcdo_ext_cfg_t       ext_cfg;
  logic [1:0]                    gpio_out, gpio_oe, gpio_in;
  logic [1:0]                    pin_o, pin_oe, pin_lvl;
  logic [4:0]                    gnet, div_err;
  logic                          up, dn, locked, nm_err;
  logic [4:0][11:0]              hi_len, lo_len;
  int                            errors, checks_done;

  pll_clock_divider_outputs dut (.MCLK(mclk), .RST_N(rst_n),
    .REF_CLK(ref_clk), .N_DIV(n_div), .M_DIV(m_div), .K_HALF(k_half),
    .FB_MODE(fb_mode), .DIV_CFG(div_cfg), .CASCADE_CFG(casc),
    .EXT_CFG(ext_cfg), .RECONFIG(reconfig), .GPIO_OUT(gpio_out),
    .GPIO_OE(gpio_oe), .GPIO_IN(gpio_in), .EXT_POS_I(pin_lvl[0]),
    .EXT_POS_O(pin_o[0]), .EXT_POS_OE(pin_oe[0]), .EXT_NEG_I(pin_lvl[1]),
    .EXT_NEG_O(pin_o[1]), .EXT_NEG_OE(pin_oe[1]), .GNET_OUT(gnet),
    .PFD_UP(up), .PFD_DN(dn), .LOCKED(locked), .FB_MODE_Q(fb_q),
    .DIV_ERR(div_err), .NM_ERR(nm_err));
  pcdo_sink_model u_sink (.clk(mclk), .rst_n(rst_n), .gnet(gnet),
    .hi_len(hi_len), .lo_len(lo_len), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_lvl(pin_lvl));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Reference: 8 cycle period, off edge
  initial begin
    ref_clk = 1'b0;
    #1.3;
    forever #20 ref_clk = ~ref_clk;
  end

  // ******************
  // Tasks
  // ******************
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  task automatic do_reset(input pcdo_pkg::pcdo_ext_cfg_t e,
                          input logic [4:1] c);
    @(negedge mclk);
    rst_n = 1'b0;
    ext_cfg = e;
    casc = c;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : do_reset
  task automatic reload(input int w);
    @(negedge mclk);
    reconfig = 1'b1;
    @(negedge mclk);
    reconfig = 1'b0;
    repeat (w) @(negedge mclk);
  endtask : reload
  task automatic t_duty();
    for (int m = 0; m < 4; m++) begin
      fb_mode = pcdo_pkg::pcdo_fb_mode_t'(m);
      for (int i = 0; i < 5; i++) div_cfg[i] = {9'(i+m+1), 9'(2*i+1)};
      reload(200);
      `CHK("mode", fb_mode, fb_q)
      for (int i = 0; i < 5; i++) begin
        `CHK("hi", 12'(i+m+1), hi_len[i])
        `CHK("lo", 12'(2*i+1), lo_len[i])
      end
    end
  endtask : t_duty
  task automatic t_range();
    div_cfg = {{9'h101, 9'h101}, {9'h000, 9'h004}, {9'h0C8, 9'h039},
               {9'h0C8, 9'h038}, {9'h100, 9'h100}};
    reload(1600);
    `CHK("err", 5'h1C, div_err)
    `CHK("dead", 3'h0, gnet[4:2])
    `CHK("hi0", 12'h100, hi_len[0])
    `CHK("lo0", 12'h100, lo_len[0])
    `CHK("hi1", 12'h0C8, hi_len[1])
    `CHK("lo1", 12'h038, lo_len[1])
  endtask : t_range
  task automatic t_khalf();
    k_half = 1'b1;
    div_cfg[0] = {9'h003, 9'h002};
    reload(100);
    `CHK("khi", 12'h006, hi_len[0])
    `CHK("klo", 12'h004, lo_len[0])
    k_half = 1'b0;
  endtask : t_khalf
  task automatic t_loop();
    reload(10);
    for (int k = 0; k < 3000 && locked !== 1'b1; k++) @(negedge mclk);
    `CHK("lock", 1'b1, locked)
    n_div = 10'h000;
    reload(10);
    `CHK("nmerr", 2'h2, {nm_err, locked})
    repeat (40) @(negedge mclk);
    `CHK("dn", 2'h1, {up, dn})
    n_div = 10'h200;
    m_div = 10'h200;
    reload(10);
    `CHK("nmmax", 1'b0, nm_err)
  endtask : t_loop
  task automatic t_cascade();
    div_cfg[0] = {9'h002, 9'h002};
    div_cfg[1] = {9'h001, 9'h001};
    do_reset(2'h0, 4'h1);
    repeat (100) @(negedge mclk);
    `CHK("chi", 12'h004, hi_len[1])
    `CHK("clo", 12'h004, lo_len[1])
    casc = 4'h0;
    reload(100);
    `CHK("keep", 12'h004, lo_len[1])
  endtask : t_cascade
  task automatic t_pins();
    div_cfg[0] = {9'h003, 9'h003};
    div_cfg[1] = {9'h002, 9'h005};
    do_reset(2'h3, 4'h0);
    repeat (20) @(negedge mclk);
    for (int k = 0; k < 12; k++) begin
      @(negedge mclk);
      `CHK("pos", gnet[0], pin_o[0])
      `CHK("neg", ~pin_o[0], pin_o[1])
    end
    `CHK("oe", 2'h3, pin_oe)
    `CHK("d1", 12'h005, lo_len[1])
    gpio_out = 2'h2;
    gpio_oe = 2'h2;
    do_reset(2'h2, 4'h0);
    `CHK("negio", 2'h3, {pin_o[1], pin_oe[1]})
    gpio_out = 2'h1;
    gpio_oe = 2'h3;
    do_reset(2'h0, 4'h0);
    repeat (8) @(negedge mclk);
    `CHK("gpio", 4'h7, {pin_o, pin_oe})
    `CHK("gin", 2'h1, gpio_in)
  endtask : t_pins

  // ******************
  // Sequence
  // ******************
  initial begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    n_div = 10'h002;
    m_div = 10'h010;
    k_half = 1'b0;
    reconfig = 1'b0;
    fb_mode = pcdo_pkg::PCDO_FB_NORMAL;
    div_cfg = {5{9'h001, 9'h001}};
    casc = 4'h0;
    ext_cfg = 2'h0;
    gpio_out = 2'h0;
    gpio_oe = 2'h0;
    do_reset(2'h0, 4'h0);
    t_duty();
    t_range();
    t_khalf();
    t_loop();
    t_cascade();
    t_pins();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    test_done();
  end
endmodule : pll_clock_divider_outputs_bench
